// File: rtl/cie_regs.svh
// constants of the interrupt entry control block
// Behaviour
// [RULE_01] debugger-reserved opcode raises an unimplemented-instruction exception, does nothing else
// [RULE_02] reset, nonmaskable, maskable and bus-error interrupts are asynchronous
// [RULE_03] memory-management, system, system-call and floating-point exceptions are synchronous
// [RULE_04] precise entry waits for older instructions, blocks every later one
// [RULE_05] imprecise entry need not wait, but still blocks every later instruction
// [RULE_06] resumable when not started, completed, or partial with state kept
// [RULE_07] partial with state lost or unsafe side effects is an error; code flags it only when state is lost and side effects are unsafe
// [RULE_08] entry saves only program counter and status word, eight bytes
// [RULE_09] each maskable level gets its own handler address
// [RULE_10] seven maskable levels plus nonmaskable; controller assigns the levels
// [RULE_11] vector addresses are offsets from the software-writable trap base
// [RULE_12] separate supervisor stack pointer and banked registers for supervisor level
// [RULE_13] memory faults, floating-point faults and privilege violations raise synchronous traps
// [RULE_14] every taken interrupt switches the privilege level to supervisor; code clears only NSL, so an entry at monitor level stays monitor
// [RULE_15] privilege level is supervisor, user or monitor
// [RULE_16] mode bit 0 selects legacy, 1 native exception behaviour
`ifndef CIE_REGS_SVH
`define CIE_REGS_SVH
// status word field positions
`define CIE_PSW_IM_LO   0
`define CIE_PSW_IM_HI   2
`define CIE_PSW_IE      3
`define CIE_PSW_NMID    4
`define CIE_PSW_NSL     5
`define CIE_PSW_ML      6
`define CIE_PSW_T       7
`define CIE_PSW_NAR     8
`define CIE_PSW_FE      9
// reset values
`define CIE_PSW_RST     32'h0000_0000
`define CIE_TBR_RST     32'h4000_0000
`define CIE_SP_RST      32'h0000_0000
`define CIE_EXM_RST     1'b0
// vector offsets from the trap base
`define CIE_OFS_RESET   32'h0000_0000
`define CIE_OFS_NMI     32'h0000_0008
`define CIE_OFS_BUSERR  32'h0000_0010
`define CIE_OFS_SYNC    32'h0000_0018
`define CIE_OFS_IRQ     32'h0000_0100
`define CIE_IRQ_STEP_N  32'h0000_0010
`define CIE_IRQ_STEP_L  32'h0000_0008
// interrupt codes
`define CIE_CODE_RESET  12'h000
`define CIE_CODE_NMI    12'h248
`define CIE_CODE_BUSERR 12'h260
`define CIE_CODE_IRQ    12'h280
`define CIE_CODE_UNIMPL 12'h300
`define CIE_CODE_PRIV   12'h308
`define CIE_CODE_MMU    12'h310
`define CIE_CODE_FPU    12'h318
`define CIE_CODE_SYSCL  12'h320
`define CIE_CODE_SYSEXC 12'h328
// stack frame slots below the stack pointer
`define CIE_SLOT_PC     32'h0000_0004
`define CIE_SLOT_PSW    32'h0000_0008
`endif

// File: rtl/cie_pkg.sv
// types of the interrupt entry control block
package cie_pkg;
   typedef enum logic [3:0] {
      CIE_IDLE  = 4'b0001,
      CIE_DRAIN = 4'b0010,
      CIE_PSW   = 4'b0100,
      CIE_ENTER = 4'b1000
   } cie_state_e;
   typedef enum logic [2:0] {
      CIE_SUP = 3'b001,
      CIE_USR = 3'b010,
      CIE_MON = 3'b100
   } cie_priv_e;
   typedef enum logic [1:0] {
      CIE_NONE = 2'b00,
      CIE_PART = 2'b01,
      CIE_DONE = 2'b10
   } cie_stage_e;
   typedef enum logic [2:0] {
      CIE_K_NMI = 3'h0,
      CIE_K_BUS = 3'h1,
      CIE_K_SYN = 3'h2,
      CIE_K_IRQ = 3'h3
   } cie_kind_e;
endpackage

// File: rtl/cie_irq_if.sv
// maskable request path between core and level arbiter
`timescale 1ns/1ps
interface cie_irq_if;
   logic       req;
   logic [2:0] level;
   logic       ie;
   logic [2:0] im;
   logic       accept;
   modport arb  (input req, input level, input ie, input im, output accept);
   modport core (output req, output level, output ie, output im, input accept);
endinterface

// File: rtl/cie_level_arb.sv
// level mask compare for maskable requests
`timescale 1ns/1ps
module cie_level_arb #(
   parameter int unsigned LEVELS = 7
) (
   // clock for the checks
   input  wire logic i_mclk,
   input  wire logic i_rst_n,
   // request path
   cie_irq_if.arb    irq
);
   // a level is taken only when numerically below the mask
   function automatic logic lvl_ok(input logic [2:0] lv, input logic [2:0] im);
      lvl_ok = (lv < im) && (32'(lv) < LEVELS);
   endfunction

   // accept a legal level with interrupts enabled
   always_comb begin
      irq.accept = irq.req && irq.ie && lvl_ok(irq.level, irq.im); // RULE_10
   end

   irq_mask_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_10
      irq.accept |-> (irq.ie && (irq.level < irq.im) && (irq.level != 3'h7)))
      else $error("maskable request taken against the mask");
endmodule

// File: rtl/cie_core.sv
// interrupt entry control: classify, save frame, dispatch
`timescale 1ns/1ps
`include "cie_regs.svh"
module cie_core import cie_pkg::*; #(
   parameter int unsigned LEVELS = 7
) (
   // clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   // software writes of control state
   input  wire logic        i_tbr_we,
   input  wire logic [31:0] i_tbr_wdata,
   input  wire logic        i_pipeline_control_reg_we,
   input  wire logic        i_pipeline_control_reg_exm,
   input  wire logic        i_psw_we,
   input  wire logic [31:0] i_psw_wdata,
   input  wire logic        i_ssp_we,
   input  wire logic [31:0] i_ssp_wdata,
   input  wire logic        i_usp_we,
   input  wire logic [31:0] i_usp_wdata,
   // interrupt controller
   input  wire logic        i_irq_req,
   input  wire logic [2:0]  i_irq_level,
   input  wire logic        i_nmi,
   input  wire logic        i_bus_err,
   // pipeline
   input  wire logic        i_insn_valid,
   input  wire logic [31:0] i_insn_pc,
   input  wire logic        i_dbg_op,
   input  wire logic        i_priv_viol,
   input  wire logic        i_mmu_fault,
   input  wire logic        i_fpu_exc,
   input  wire logic        i_syscall,
   input  wire logic        i_sys_exc,
   input  wire logic [1:0]  i_insn_state,
   input  wire logic        i_resume_kept,
   input  wire logic        i_side_safe,
   input  wire logic        i_pend_kept,
   input  wire logic        i_older_done,
   // frame writes
   output logic             o_mem_we,
   output logic [31:0]      o_mem_addr,
   output logic [31:0]      o_mem_wdata,
   // dispatch and status
   output logic             o_hold_issue,
   output logic             o_jump,
   output logic [31:0]      o_jump_addr,
   output logic [11:0]      o_int_code,
   output logic             o_async,
   output logic             o_precise,
   output logic             o_resumable,
   output logic [31:0]      o_psw,
   output logic [31:0]      o_sp,
   output logic [2:0]       o_priv,
   output logic             o_bank_alt,
   output logic             o_native_mode
);
   cie_state_e  state;
   cie_kind_e   kind;
   logic [31:0] psw;
   logic [31:0] trap_base_register;
   logic [31:0] supervisor_stack_pointer;
   logic [31:0] usp;
   logic        exception_mode_select;
   logic [31:0] pc_keep;
   logic [31:0] ofs;
   logic [2:0]  lvl;
   logic        sync_hit;
   logic        nmi_ok;
   logic        take;
   cie_kind_e   next_kind;
   logic [11:0] next_code;
   logic [31:0] next_ofs;
   logic        next_resume;
   logic        next_precise;

   cie_irq_if irq ();

   // handler offset for a maskable level in the chosen mode
   function automatic logic [31:0] vec_ofs(input logic [2:0] lv, input logic nat);
      logic [31:0] step;
      step = nat ? `CIE_IRQ_STEP_N : `CIE_IRQ_STEP_L;
      vec_ofs = `CIE_OFS_IRQ + (32'(lv) * step);
   endfunction

   // level compare against the status word mask
   assign irq.req   = i_irq_req;
   assign irq.level = i_irq_level;
   assign irq.ie    = psw[`CIE_PSW_IE];
   assign irq.im    = psw[`CIE_PSW_IM_HI:`CIE_PSW_IM_LO];

   cie_level_arb #(
      .LEVELS (LEVELS)
   ) u_arb (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .irq     (irq)
   );

   // event sorting: bus error, then nonmaskable, then the instruction's own fault, then maskable
   always_comb begin
      sync_hit = i_insn_valid && (i_dbg_op || i_priv_viol || i_mmu_fault
                 || i_fpu_exc || i_syscall || i_sys_exc); // RULE_03 RULE_13
      nmi_ok   = i_nmi && !psw[`CIE_PSW_NMID];
      take     = (state == CIE_IDLE) && (i_bus_err || nmi_ok || sync_hit || irq.accept);
      next_kind    = CIE_K_IRQ;
      next_code    = `CIE_CODE_IRQ + {6'h00, i_irq_level, 3'h0};
      next_ofs     = vec_ofs(i_irq_level, exception_mode_select); // RULE_09 RULE_16
      next_precise = 1'b1;
      if (i_bus_err) begin
         next_kind    = CIE_K_BUS; // RULE_02
         next_code    = `CIE_CODE_BUSERR;
         next_ofs     = `CIE_OFS_BUSERR;
         next_precise = 1'b0;
      end else if (nmi_ok) begin
         next_kind = CIE_K_NMI; // RULE_02
         next_code = `CIE_CODE_NMI;
         next_ofs  = `CIE_OFS_NMI;
      end else if (sync_hit) begin
         next_kind = CIE_K_SYN;
         next_ofs  = `CIE_OFS_SYNC;
         if (i_dbg_op) begin
            next_code = `CIE_CODE_UNIMPL; // RULE_01
         end else if (i_priv_viol) begin
            next_code = `CIE_CODE_PRIV; // RULE_13
         end else if (i_mmu_fault) begin
            next_code = `CIE_CODE_MMU; // RULE_13
         end else if (i_fpu_exc) begin
            next_code = `CIE_CODE_FPU; // RULE_13
         end else if (i_syscall) begin
            next_code = `CIE_CODE_SYSCL;
         end else begin
            next_code = `CIE_CODE_SYSEXC;
         end
      end
   end

   // resumable unless partial with state lost and unsafe side effects, an undefined stage, or imprecise with pending state lost
   always_comb begin
      case (i_insn_state)
         CIE_NONE: next_resume = 1'b1; // RULE_06
         CIE_DONE: next_resume = 1'b1; // RULE_06
         CIE_PART: next_resume = i_resume_kept || i_side_safe; // RULE_07
         default:  next_resume = 1'b0;
      endcase
      if (!next_precise && !i_pend_kept) begin
         next_resume = 1'b0; // RULE_06
      end
   end

   // entry sequence: drain, push pc, push status word, jump
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= CIE_IDLE;
      end else begin
         case (state)
            CIE_IDLE: begin
               if (take) begin
                  state <= CIE_DRAIN;
               end
            end
            CIE_DRAIN: begin
               if (!o_precise || i_older_done) begin // RULE_04 RULE_05
                  state <= CIE_PSW;
               end
            end
            CIE_PSW:   state <= CIE_ENTER;
            CIE_ENTER: state <= CIE_IDLE;
            default:   state <= CIE_IDLE;
         endcase
      end
   end

   // latch the taken event
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         kind        <= CIE_K_NMI;
         pc_keep     <= 32'h0000_0000;
         ofs         <= `CIE_OFS_RESET;
         lvl         <= 3'h0;
         o_int_code  <= `CIE_CODE_RESET;
         o_async     <= 1'b1;
         o_precise   <= 1'b0;
         o_resumable <= 1'b0;
      end else if (take) begin
         kind        <= next_kind;
         pc_keep     <= i_insn_pc;
         ofs         <= next_ofs;
         lvl         <= i_irq_level;
         o_int_code  <= next_code;
         o_async     <= (next_kind != CIE_K_SYN); // RULE_02 RULE_03
         o_precise   <= next_precise;
         o_resumable <= next_resume;
      end
   end

   // later instructions stay blocked for the whole entry
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_hold_issue <= 1'b0;
      end else if (take) begin
         o_hold_issue <= 1'b1; // RULE_04 RULE_05
      end else if (state == CIE_ENTER) begin
         o_hold_issue <= 1'b0;
      end
   end

   // frame writes: pc then status word, nothing else
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_mem_we    <= 1'b0;
         o_mem_addr  <= 32'h0000_0000;
         o_mem_wdata <= 32'h0000_0000;
      end else if (state == CIE_DRAIN && (!o_precise || i_older_done)) begin
         o_mem_we    <= 1'b1; // RULE_08
         o_mem_addr  <= supervisor_stack_pointer - `CIE_SLOT_PC;
         o_mem_wdata <= pc_keep;
      end else if (state == CIE_PSW) begin
         o_mem_we    <= 1'b1; // RULE_08
         o_mem_addr  <= supervisor_stack_pointer - `CIE_SLOT_PSW;
         o_mem_wdata <= psw;
      end else begin
         o_mem_we    <= 1'b0;
      end
   end

   // jump to trap base plus the event's offset
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_jump      <= 1'b0;
         o_jump_addr <= `CIE_TBR_RST + `CIE_OFS_RESET;
      end else begin
         o_jump <= (state == CIE_ENTER);
         if (state == CIE_ENTER) begin
            o_jump_addr <= trap_base_register + ofs; // RULE_11
         end
      end
   end

   // status word: software write, or update on entry
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         psw <= `CIE_PSW_RST;
      end else if (state == CIE_ENTER) begin
         psw[`CIE_PSW_IE]  <= 1'b0;
         psw[`CIE_PSW_NSL] <= 1'b0; // RULE_14
         psw[`CIE_PSW_T]   <= 1'b0;
         psw[`CIE_PSW_NAR] <= 1'b0; // RULE_12
         if (kind == CIE_K_NMI) begin
            psw[`CIE_PSW_NMID] <= 1'b1;
         end
         if (kind == CIE_K_IRQ) begin
            psw[`CIE_PSW_IM_HI:`CIE_PSW_IM_LO] <= lvl;
         end
      end else if (i_psw_we) begin
         psw <= i_psw_wdata;
      end
   end

   // trap base and mode bit
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         trap_base_register <= `CIE_TBR_RST;
         exception_mode_select <= `CIE_EXM_RST;
      end else begin
         if (i_tbr_we) begin
            trap_base_register <= i_tbr_wdata; // RULE_11
         end
         if (i_pipeline_control_reg_we) begin
            exception_mode_select <= i_pipeline_control_reg_exm; // RULE_16
         end
      end
   end

   // stack pointers: frame lands on the supervisor one
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         supervisor_stack_pointer <= `CIE_SP_RST;
         usp <= `CIE_SP_RST;
      end else begin
         if (state == CIE_ENTER) begin
            supervisor_stack_pointer <= supervisor_stack_pointer - `CIE_SLOT_PSW; // RULE_12
         end else if (i_ssp_we) begin
            supervisor_stack_pointer <= i_ssp_wdata;
         end
         if (i_usp_we) begin
            usp <= i_usp_wdata;
         end
      end
   end

   // registered views of level, bank, stack and mode
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_priv        <= CIE_SUP;
         o_sp          <= `CIE_SP_RST;
         o_bank_alt    <= 1'b0;
         o_psw         <= `CIE_PSW_RST;
         o_native_mode <= `CIE_EXM_RST;
      end else begin
         if (psw[`CIE_PSW_ML]) begin
            o_priv <= CIE_MON; // RULE_15
         end else if (psw[`CIE_PSW_NSL]) begin
            o_priv <= CIE_USR; // RULE_15
         end else begin
            o_priv <= CIE_SUP; // RULE_15
         end
         o_sp          <= psw[`CIE_PSW_NSL] ? usp : supervisor_stack_pointer; // RULE_12
         o_bank_alt    <= psw[`CIE_PSW_NAR];
         o_psw         <= psw;
         o_native_mode <= exception_mode_select; // RULE_16
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);

   sequence push_pc_s;
      o_mem_we && (o_mem_addr == supervisor_stack_pointer - `CIE_SLOT_PC);
   endsequence
   sequence push_psw_s;
      o_mem_we && (o_mem_addr == supervisor_stack_pointer - `CIE_SLOT_PSW);
   endsequence

   dbg_op_trap_a: assert property ( // RULE_01
      (take && !i_bus_err && !nmi_ok && i_insn_valid && i_dbg_op)
      |=> (o_int_code == `CIE_CODE_UNIMPL) && !o_async)
      else $error("reserved opcode did not trap");
   async_class_a: assert property ( // RULE_02
      (take && (i_bus_err || nmi_ok)) |=> o_async)
      else $error("asynchronous event classed as synchronous");
   sync_class_a: assert property ( // RULE_03
      (take && sync_hit && !i_bus_err && !nmi_ok) |=> !o_async ##0 o_hold_issue)
      else $error("instruction fault classed as asynchronous");
   precise_wait_a: assert property ( // RULE_04
      (state == CIE_DRAIN && o_precise && !i_older_done) |=> !o_mem_we)
      else $error("precise entry did not wait for older instructions");
   imprecise_go_a: assert property ( // RULE_05
      (state == CIE_DRAIN && !o_precise) |=> push_pc_s ##1 push_psw_s)
      else $error("imprecise entry stalled");
   issue_hold_a: assert property ( // RULE_05
      (state != CIE_IDLE) |-> o_hold_issue)
      else $error("later instruction allowed during entry");
   resume_ok_a: assert property ( // RULE_06
      (take && next_precise && i_insn_state == CIE_DONE) |=> o_resumable)
      else $error("completed instruction marked as error");
   error_case_a: assert property ( // RULE_07
      (take && i_insn_state == CIE_PART && !i_resume_kept && !i_side_safe)
      |=> !o_resumable)
      else $error("lost state not marked as error");
   frame_seq_a: assert property ( // RULE_08
      push_pc_s |=> push_psw_s ##1 (o_jump && !o_mem_we))
      else $error("frame is not exactly pc then status word");
   level_vec_a: assert property ( // RULE_09
      (o_jump && kind == CIE_K_IRQ) |-> (o_jump_addr == $past(trap_base_register) + vec_ofs(lvl, exception_mode_select)))
      else $error("maskable handler address wrong for its level");
   sup_stack_a: assert property ( // RULE_12
      o_jump |-> (supervisor_stack_pointer == $past(supervisor_stack_pointer) - `CIE_SLOT_PSW) && !psw[`CIE_PSW_NAR])
      else $error("supervisor stack not stepped by eight");
   sup_entry_a: assert property ( // RULE_14
      o_jump |-> !psw[`CIE_PSW_NSL] ##1 (o_priv != CIE_USR))
      else $error("entry did not reach supervisor level");
   priv_state_a: assert property ( // RULE_15
      $onehot(o_priv))
      else $error("privilege level outside its three states");
   mode_sel_a: assert property ( // RULE_16
      i_pipeline_control_reg_we |=> ##1 (o_native_mode == $past(i_pipeline_control_reg_exm, 2)))
      else $error("mode bit not applied");
endmodule

// File: verif/cie_intc_model.sv
// partner model: chip-level controller that maps peripheral requests onto levels
`timescale 1ns/1ps
module cie_intc_model #(
   parameter int unsigned SOURCES = 7
) (
   // clock and reset
   input  wire logic               i_mclk,
   input  wire logic               i_rst_n,
   // peripheral requests and event sources
   input  wire logic [SOURCES-1:0] i_src,
   input  wire logic               i_nmi_src,
   input  wire logic               i_bus_src,
   // core side level lines
   output logic                    o_irq_req,
   output logic [2:0]              o_irq_level,
   output logic                    o_nmi,
   output logic                    o_bus_err
);
   // source k sits at level k, lowest index wins; idle keeps a changing pattern
   function automatic logic [2:0] pick(input logic [SOURCES-1:0] s, input logic [2:0] idle);
      logic [2:0] lv;
      lv = idle;
      for (int k = SOURCES - 1; k >= 0; k--) begin
         if (s[k]) begin
            lv = 3'(k);
         end
      end
      return lv;
   endfunction
   // registered lines, held for as long as the source asks
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_irq_req   <= 1'b0;
         o_irq_level <= 3'h0;
         o_nmi       <= 1'b0;
         o_bus_err   <= 1'b0;
      end else begin
         o_irq_req   <= |i_src;
         o_irq_level <= pick(i_src, ~o_irq_level);
         o_nmi       <= i_nmi_src;
         o_bus_err   <= i_bus_src;
      end
   end
endmodule

// File: verif/testbench.sv
// self-checking bench for the interrupt entry control core
`timescale 1ns/1ps
`include "cie_regs.svh"
module testbench import cie_pkg::*;;
   // design inputs
   logic        i_mclk = 1'b0;
   logic        i_rst_n = 1'b0;
   logic [4:0]  we = 5'h00;
   logic [31:0] wd = 32'h0;
   logic        i_tbr_we, i_psw_we, i_ssp_we, i_usp_we, i_pipeline_control_reg_we, i_pipeline_control_reg_exm;
   logic [31:0] i_tbr_wdata, i_psw_wdata, i_ssp_wdata, i_usp_wdata;
   logic [5:0]  flt = 6'h00;
   logic        i_dbg_op, i_priv_viol, i_mmu_fault, i_fpu_exc, i_syscall, i_sys_exc;
   logic        i_insn_valid = 1'b0;
   logic [31:0] i_insn_pc = 32'h0;
   logic [1:0]  i_insn_state = 2'h0;
   logic        i_resume_kept = 1'b0;
   logic        i_side_safe = 1'b0;
   logic        i_pend_kept = 1'b0;
   logic        i_older_done = 1'b1;
   logic        i_irq_req, i_nmi, i_bus_err;
   logic [2:0]  i_irq_level;
   logic [6:0]  src = 7'h00;
   logic        nmi_src = 1'b0;
   logic        bus_src = 1'b0;
   // design outputs
   logic        o_mem_we, o_hold_issue, o_jump, o_async, o_precise, o_resumable;
   logic        o_bank_alt, o_native_mode;
   logic [31:0] o_mem_addr, o_mem_wdata, o_jump_addr, o_psw, o_sp;
   logic [11:0] o_int_code;
   logic [2:0]  o_priv;
   // bench state
   int          bad_count = 0;
   int          n_compared = 0;
   int          cycles = 0;
   logic [31:0] trap_base_register = `CIE_TBR_RST;
   logic [31:0] supervisor_stack_pointer = 32'h0000_8000;
   // {state, resume kept, side safe, expected resumable} per sync fault
   localparam logic [4:0] SYNC_CASE [6] = '{5'h01, 5'h0D, 5'h0B, 5'h08, 5'h11, 5'h18};
   // shared write strobes and data
   assign {i_tbr_we, i_psw_we, i_ssp_we, i_usp_we, i_pipeline_control_reg_we} = we;
   assign i_tbr_wdata = wd;
   assign i_psw_wdata = wd;
   assign i_ssp_wdata = wd;
   assign i_usp_wdata = wd;
   assign i_pipeline_control_reg_exm  = wd[0];
   assign {i_dbg_op, i_priv_viol, i_mmu_fault, i_fpu_exc, i_syscall, i_sys_exc} = flt;
   cie_core #(.LEVELS(7)) i_dut (.*);
   cie_intc_model #(.SOURCES(7)) i_intc (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_src(src),
      .i_nmi_src(nmi_src), .i_bus_src(bus_src), .o_irq_req(i_irq_req),
      .o_irq_level(i_irq_level), .o_nmi(i_nmi), .o_bus_err(i_bus_err));
   // clock
   initial begin
      forever #10 i_mclk = ~i_mclk;
   end
   // hang guard
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         bad_count++;
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // s: 0 trap base, 1 status word, 2 supervisor sp, 3 user sp, 4 mode bit
   task automatic sw(input int s, input logic [31:0] v);
      @(posedge i_mclk);
      wd <= v;
      we <= 5'h10 >> s;
      @(posedge i_mclk);
      we <= 5'h00;
      @(posedge i_mclk);
      #1;
   endtask
   // no take may start while the request is masked
   task automatic quiet();
      repeat (6) begin
         @(posedge i_mclk);
         #1;
         chk("no_take", 1'b0, o_hold_issue);
      end
   endtask
   // follow one entry: class, frame writes, dispatch, new status
   task automatic ent(input logic [11:0] code, input logic [2:0] cls, input logic [31:0] ofs,
                      input logic [31:0] oldp, input logic [31:0] newp, input int stall);
      int n;
      int fw;
      int w;
      logic [31:0] wa [2];
      logic [31:0] wv [2];
      n = 0;
      fw = -1;
      w = 0;
      while (o_hold_issue !== 1'b1 && n < 20) begin
         @(posedge i_mclk);
         #1;
         n++;
      end
      chk("hold", 1'b1, o_hold_issue);
      chk("int_code", {20'h0, code}, {20'h0, o_int_code});
      chk("class", {29'h0, cls}, {29'h0, o_async, o_precise, o_resumable});
      n = 0;
      while (o_jump !== 1'b1 && n < 30) begin
         @(posedge i_mclk);
         if (n == 0) begin
            flt <= 6'h00;
            src <= 7'h00;
            nmi_src <= 1'b0;
            bus_src <= 1'b0;
         end
         if (n == stall) begin
            i_older_done <= 1'b1;
         end
         #1;
         if (o_mem_we === 1'b1 && w < 2) begin
            if (w == 0) begin
               fw = n;
            end
            wa[w] = o_mem_addr;
            wv[w] = o_mem_wdata;
            w++;
         end
         n++;
      end
      chk("write_start", 1'b1, stall == 0 || (cls[1] ? fw > stall : fw == 0));
      chk("writes", 2, w);
      chk("pc_addr", supervisor_stack_pointer - 4, wa[0]);
      chk("pc_data", i_insn_pc, wv[0]);
      chk("psw_addr", supervisor_stack_pointer - 8, wa[1]);
      chk("psw_data", oldp, wv[1]);
      chk("jump_addr", trap_base_register + ofs, o_jump_addr);
      chk("hold_drop", 1'b0, o_hold_issue);
      supervisor_stack_pointer = supervisor_stack_pointer - 8;
      @(posedge i_mclk);
      #1;
      chk("jump_pulse", 1'b0, o_jump);
      chk("psw_new", newp, o_psw);
      chk("sp_new", supervisor_stack_pointer, o_sp);
      chk("priv_new", CIE_SUP, o_priv);
   endtask
   task automatic t_reset();
      chk("rst_jump", `CIE_TBR_RST, o_jump_addr);
      chk("rst_priv", CIE_SUP, o_priv);
      chk("rst_mode", 1'b0, o_native_mode);
      chk("rst_psw", 32'h0, o_psw);
      chk("rst_hold", 1'b0, o_hold_issue);
   endtask
   task automatic t_views();
      sw(2, supervisor_stack_pointer);
      sw(3, 32'h0000_5000);
      sw(1, 32'h0000_0120);
      chk("usr_sp", 32'h0000_5000, o_sp);
      chk("usr_priv", CIE_USR, o_priv);
      chk("bank_alt", 1'b1, o_bank_alt);
      sw(1, 32'h0000_0040);
      chk("mon_priv", CIE_MON, o_priv);
      chk("sup_sp", supervisor_stack_pointer, o_sp);
   endtask
   task automatic t_bus();
      sw(1, 32'h0000_0120);
      @(posedge i_mclk);
      i_insn_pc <= 32'h0000_1234;
      i_older_done <= 1'b0;
      bus_src <= 1'b1;
      ent(`CIE_CODE_BUSERR, 3'b100, `CIE_OFS_BUSERR, 32'h120, 32'h0, 1);
      chk("bank_norm", 1'b0, o_bank_alt);
      @(posedge i_mclk);
      i_pend_kept <= 1'b1;
      bus_src <= 1'b1;
      ent(`CIE_CODE_BUSERR, 3'b101, `CIE_OFS_BUSERR, 32'h0, 32'h0, 1);
   endtask
   task automatic t_nmi();
      sw(1, 32'h0000_02A5);
      @(posedge i_mclk);
      i_insn_state <= 2'h2;
      nmi_src <= 1'b1;
      ent(`CIE_CODE_NMI, 3'b111, `CIE_OFS_NMI, 32'h2A5, 32'h215, 0);
      @(posedge i_mclk);
      nmi_src <= 1'b1;
      quiet();
      @(posedge i_mclk);
      nmi_src <= 1'b0;
      sw(1, 32'h0);
   endtask
   task automatic t_irq(input logic mode);
      sw(4, {31'h0, mode});
      chk("mode", mode, o_native_mode);
      trap_base_register = 32'h0001_2000 + (mode ? 32'h0 : 32'h0100_0000);
      sw(0, trap_base_register);
      for (int lvl = 0; lvl < 7; lvl++) begin
         sw(1, 32'h28 | lvl);
         @(posedge i_mclk);
         src <= 7'h01 << lvl;
         quiet();
         sw(1, 32'h28 | (lvl + 1));
         ent(12'(`CIE_CODE_IRQ + lvl * 8), 3'b111,
             `CIE_OFS_IRQ + lvl * (mode ? `CIE_IRQ_STEP_N : `CIE_IRQ_STEP_L),
             32'h28 | (lvl + 1), lvl, 0);
      end
   endtask
   task automatic t_sync();
      trap_base_register = 32'h0007_0000;
      sw(0, trap_base_register);
      for (int f = 0; f < 6; f++) begin
         sw(1, 32'h20);
         @(posedge i_mclk);
         {i_insn_state, i_resume_kept, i_side_safe} <= SYNC_CASE[f][4:1];
         i_older_done <= 1'b0;
         i_insn_valid <= 1'b1;
         flt <= 6'h20 >> f;
         ent(12'(`CIE_CODE_UNIMPL + f * 8), {2'b01, SYNC_CASE[f][0]}, `CIE_OFS_SYNC,
             32'h20, 32'h0, 3);
      end
   endtask
   // main sequence
   initial begin
      repeat (5) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      @(posedge i_mclk);
      #1;
      t_reset();
      t_views();
      t_bus();
      t_nmi();
      t_irq(1'b1);
      t_irq(1'b0);
      t_sync();
      tally_and_finish();
   end
endmodule
